// >>> core/sppw_defs.vh
/*
  constants of the port-protocol wrapper: register map, field
  positions, reset values and mode encodings.
  assumes byte addressing on an 8-bit APB address, one word per register.
*/
`ifndef SPPW_DEFS_VH
`define SPPW_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPPW_OFF_CTRL    8'h00
`define SPPW_OFF_ADDEND  8'h04
`define SPPW_OFF_OFSLO   8'h08
`define SPPW_OFF_OFSHI   8'h0C
`define SPPW_OFF_STATUS  8'h10
`define SPPW_OFF_RESULT  8'h14
`define SPPW_OFF_CALLS   8'h18

// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define SPPW_CTL_W       15
`define SPPW_CTL_MODE    1:0
`define SPPW_CTL_ASTY    4:2
`define SPPW_CTL_BSTY    7:5
`define SPPW_CTL_AREG    8
`define SPPW_CTL_BREG    9
`define SPPW_CTL_SREG    11:10
`define SPPW_CTL_A64     12
`define SPPW_CTL_OFS     14:13
`define SPPW_CTRL_RST    15'h0C01

// ------------------------------------------------------------
// block control modes
// ------------------------------------------------------------
`define SPPW_CM_NONE     2'h0
`define SPPW_CM_HS       2'h1
`define SPPW_CM_CHAIN    2'h2

// ------------------------------------------------------------
// argument port styles
// ------------------------------------------------------------
`define SPPW_ST_PLAIN    3'h0
`define SPPW_ST_STEADY   3'h1
`define SPPW_ST_VALID    3'h2
`define SPPW_ST_ACK      3'h3
`define SPPW_ST_HS       3'h4
`define SPPW_ST_OVLD     3'h5
`define SPPW_ST_QUEUE    3'h6

// ------------------------------------------------------------
// stream register placement and offset sources
// ------------------------------------------------------------
`define SPPW_SR_FWD      2'h1
`define SPPW_SR_REV      2'h2
`define SPPW_SR_BOTH     2'h3
`define SPPW_OS_OFF      2'h0
`define SPPW_OS_DIRECT   2'h1
`define SPPW_OS_SLAVE    2'h2

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define SPPW_RAM_AW      8
`define SPPW_RAM_BUS_W   42

`endif

// >>> core/sppw_core.v
/*
  port-protocol wrapper around a small function: result = a + mem[a]
  + addend, written back to memory and to the output argument, plus an
  independent stream path adding the same addend.
  assumes an APB master on the same clock, and upstream, downstream and
  memory logic on the same clock, so no input synchronisers are needed.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
// Summary of operation
// - plain style is a bare data port
// - valid style adds companion valid signal
// - acknowledge style adds companion acknowledge signal
// - handshake style carries valid and acknowledge
// - output-valid only on outputs, inputs plain
// - queue style uses active-low empty, full
// - queue style only on one-way arguments
// - discrete memory port, separate address, data, control
// - bundled memory port as one interface
// - stream port uses data, valid, ready
// - master address 32 or 64 bits wide
// - offset none, direct port, or register
// - all slave registers share one port
// - slave port runs on system clock
// - start, idle, done, ready block control
// - chained control adds continue from downstream
// - no-control mode drops block control ports; here the ports stay, idle, done and ready held low, start ignored
// - register option holds data to call end
// - stream registered forward, reverse or both
// - stream side channel registered with data
`timescale 1ns/1ns
`include "sppw_defs.vh"

module sppw_core (
   input  wire        clock,
   input  wire        rst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        start,
   input  wire        continueIn,
   output wire        idle,
   output wire        done,
   output wire        ready,
   input  wire [31:0] argAData,
   input  wire        argAValid,
   output wire        argAAck,
   input  wire        argAEmptyN,
   output wire        argARead,
   output wire [31:0] argBData,
   output wire        argBValid,
   input  wire        argBAck,
   input  wire        argBFullN,
   output wire        argBWrite,
   output wire [7:0]  ramAddr,
   output wire        ramCe,
   output wire        ramWe,
   output wire [31:0] ramWData,
   input  wire [31:0] ramRData,
   output wire [41:0] ramBus,
   input  wire [63:0] offsetIn,
   output wire [63:0] mstAddr,
   input  wire [31:0] sTdata,
   input  wire        sTlast,
   input  wire        sTvalid,
   output wire        sTready,
   output wire [31:0] mTdata,
   output wire        mTlast,
   output wire        mTvalid,
   input  wire        mTready
);

// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam S_IDLE = 3'h0;
localparam S_READ = 3'h1;
localparam S_MEM  = 3'h2;
localparam S_CALC = 3'h3;
localparam S_WRB  = 3'h4;
localparam S_FIN  = 3'h5;

// ------------------------------------------------------------
// declarations
// ------------------------------------------------------------
reg  [`SPPW_CTL_W-1:0]  ctrl_q;
reg  [31:0]             addend_q;
reg  [31:0]             ofsLo_q;
reg  [31:0]             ofsHi_q;
reg  [31:0]             prdata_q;
reg  [2:0]              state_q;
reg  [31:0]             aHold_q;
reg  [31:0]             result_q;
reg  [31:0]             bData_q;
reg                     bValid_q;
reg  [`SPPW_RAM_AW-1:0] ramAddr_q;
reg                     ramCe_q;
reg                     ramWe_q;
reg  [31:0]             ramWData_q;
reg  [63:0]             mstAddr_q;
reg  [31:0]             calls_q;
reg                     mainV_q;
reg  [31:0]             mainD_q;
reg                     mainL_q;
reg                     skidV_q;
reg  [31:0]             skidD_q;
reg                     skidL_q;
reg  [31:0]             rdMux;
reg                     mapped;
reg                     aTake;
reg                     bDone;
reg  [63:0]             ofsBase;

wire [1:0]  ctlMode  = ctrl_q[`SPPW_CTL_MODE];
wire [2:0]  aStyle   = ctrl_q[`SPPW_CTL_ASTY];
wire [2:0]  bStyle   = ctrl_q[`SPPW_CTL_BSTY];
wire [1:0]  sMode    = ctrl_q[`SPPW_CTL_SREG];
wire        apbSetup = psel & ~penable;
wire        apbWr    = psel & penable & pwrite;
wire        hasCtl   = (ctlMode != `SPPW_CM_NONE);
wire        isChain  = (ctlMode == `SPPW_CM_CHAIN);
wire        inRead   = (state_q == S_READ);
wire        inWrb    = (state_q == S_WRB);

// ------------------------------------------------------------
// APB slave: one port for all registers, on the system clock
// ------------------------------------------------------------
// zero wait states; read data is loaded in the setup cycle
always @* begin
   mapped = 1'h1;
   case (paddr)
      `SPPW_OFF_CTRL:   rdMux = {17'h0_0000, ctrl_q};
      `SPPW_OFF_ADDEND: rdMux = addend_q;
      `SPPW_OFF_OFSLO:  rdMux = ofsLo_q;
      `SPPW_OFF_OFSHI:  rdMux = ofsHi_q;
      `SPPW_OFF_STATUS: rdMux = {29'h0000_0000, state_q};
      `SPPW_OFF_RESULT: rdMux = result_q;
      `SPPW_OFF_CALLS:  rdMux = calls_q;
      default: begin
         rdMux  = 32'h0000_0000;
         mapped = 1'h0;
      end
   endcase
end

assign prdata  = prdata_q;
assign pready  = 1'h1;
assign pslverr = psel & penable & ~mapped;

always @(posedge clock or negedge rst_n) begin
   if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      ctrl_q   <= `SPPW_CTRL_RST;
      addend_q <= 32'h0000_0000;
      ofsLo_q  <= 32'h0000_0000;
      ofsHi_q  <= 32'h0000_0000;
   end else begin
      if (apbSetup) begin
         prdata_q <= rdMux;
      end
      if (apbWr) begin
         case (paddr)
            `SPPW_OFF_CTRL:   ctrl_q   <= pwdata[`SPPW_CTL_W-1:0];
            `SPPW_OFF_ADDEND: addend_q <= pwdata;
            `SPPW_OFF_OFSLO:  ofsLo_q  <= pwdata;
            `SPPW_OFF_OFSHI:  ofsHi_q  <= pwdata;
            default: begin
            end
         endcase
      end
   end
end

// ------------------------------------------------------------
// argument a: acceptance per style
// ------------------------------------------------------------
// output-valid is an output-only style, so on a treats as plain
always @* begin
   case (aStyle)
      `SPPW_ST_VALID: aTake = argAValid;
      `SPPW_ST_HS:    aTake = argAValid;
      `SPPW_ST_QUEUE: aTake = argAEmptyN;
      `SPPW_ST_ACK:   aTake = 1'h1;
      `SPPW_ST_OVLD:  aTake = 1'h1;
      default:        aTake = 1'h1;
   endcase
end

// ack confirms the read; on handshake it rises with valid
assign argAAck  = inRead & ((aStyle == `SPPW_ST_ACK) |
                  ((aStyle == `SPPW_ST_HS) & argAValid));
// queue read only on an input argument, never both ways
assign argARead = inRead & (aStyle == `SPPW_ST_QUEUE) &
                  argAEmptyN;

// a steady source needs no capture register
wire        aRegd = ctrl_q[`SPPW_CTL_AREG] &
                    (aStyle != `SPPW_ST_STEADY);
wire [31:0] aUse  = aRegd ? aHold_q : argAData;
wire [31:0] sum   = aUse + ramRData + addend_q;

// ------------------------------------------------------------
// argument b: completion per style
// ------------------------------------------------------------
always @* begin
   case (bStyle)
      `SPPW_ST_ACK:   bDone = argBAck;
      `SPPW_ST_HS:    bDone = argBAck;
      `SPPW_ST_QUEUE: bDone = argBFullN;
      default:        bDone = 1'h1;
   endcase
end

assign argBData  = bData_q;
assign argBValid = bValid_q;
assign argBWrite = inWrb & (bStyle == `SPPW_ST_QUEUE) &
                   argBFullN;

// ------------------------------------------------------------
// master address: width and offset source
// ------------------------------------------------------------
always @* begin
   case (ctrl_q[`SPPW_CTL_OFS])
      `SPPW_OS_DIRECT: ofsBase = offsetIn;
      `SPPW_OS_SLAVE:  ofsBase = {ofsHi_q, ofsLo_q};
      default:         ofsBase = 64'h0000_0000_0000_0000;
   endcase
end

wire [63:0] wordAddr = ofsBase + {30'h0000_0000, aUse, 2'h0};
wire [63:0] nextMst  = ctrl_q[`SPPW_CTL_A64] ? wordAddr :
                       {32'h0000_0000, wordAddr[31:0]};
assign mstAddr = mstAddr_q;

// ------------------------------------------------------------
// memory port, discrete and bundled views of the same signals
// ------------------------------------------------------------
assign ramAddr  = ramAddr_q;
assign ramCe    = ramCe_q;
assign ramWe    = ramWe_q;
assign ramWData = ramWData_q;
assign ramBus   = {ramCe_q, ramWe_q, ramAddr_q, ramWData_q};

// ------------------------------------------------------------
// block control outputs
// ------------------------------------------------------------
// in no-control mode these stay low and start is ignored
assign idle  = hasCtl & (state_q == S_IDLE);
assign ready = hasCtl & inRead & aTake;
assign done  = hasCtl & (state_q == S_FIN);

// ------------------------------------------------------------
// call sequencer
// ------------------------------------------------------------
always @(posedge clock or negedge rst_n) begin
   if (!rst_n) begin
      state_q    <= S_IDLE;
      aHold_q    <= 32'h0000_0000;
      result_q   <= 32'h0000_0000;
      bData_q    <= 32'h0000_0000;
      bValid_q   <= 1'h0;
      ramAddr_q  <= {`SPPW_RAM_AW{1'h0}};
      ramCe_q    <= 1'h0;
      ramWe_q    <= 1'h0;
      ramWData_q <= 32'h0000_0000;
      mstAddr_q  <= 64'h0000_0000_0000_0000;
      calls_q    <= 32'h0000_0000;
   end else begin
      case (state_q)
         S_IDLE: begin
            // unregistered output returns to zero between calls
            if (!ctrl_q[`SPPW_CTL_BREG]) begin
               bData_q <= 32'h0000_0000;
            end
            // start is a level; the caller keeps it up until ready
            if (!hasCtl || start) begin
               state_q <= S_READ;
            end
         end
         S_READ: begin
            if (aTake) begin
               aHold_q   <= argAData;
               ramAddr_q <= argAData[`SPPW_RAM_AW-1:0];
               ramCe_q   <= 1'h1;
               ramWe_q   <= 1'h0;
               state_q   <= S_MEM;
            end
         end
         S_MEM: begin
            // memory samples the read here; data arrives next cycle
            ramCe_q <= 1'h0;
            state_q <= S_CALC;
         end
         S_CALC: begin
            result_q   <= sum;
            bData_q    <= sum;
            ramCe_q    <= 1'h1;
            ramWe_q    <= 1'h1;
            ramWData_q <= sum;
            mstAddr_q  <= nextMst;
            bValid_q   <= (bStyle == `SPPW_ST_VALID) |
                          (bStyle == `SPPW_ST_OVLD)  |
                          (bStyle == `SPPW_ST_HS);
            state_q    <= S_WRB;
         end
         S_WRB: begin
            ramCe_q <= 1'h0;
            ramWe_q <= 1'h0;
            if (bDone) begin
               bValid_q <= 1'h0;
               calls_q  <= calls_q + 32'h0000_0001;
               state_q  <= S_FIN;
            end
         end
         S_FIN: begin
            // chained control holds done until downstream continues
            if (!isChain || continueIn) begin
               state_q <= S_IDLE;
            end
         end
         default: begin
            state_q <= S_IDLE;
         end
      endcase
   end
end

// ------------------------------------------------------------
// stream path: data plus addend, last travels with the data
// ------------------------------------------------------------
// change the placement only while the stream is empty; words held
// in one placement are not carried over to another
wire        revMode = (sMode == `SPPW_SR_REV);
wire        fwdMode = (sMode == `SPPW_SR_FWD);
wire [31:0] sSum    = sTdata + addend_q;
wire        sIn     = sTvalid & sTready;
wire        mainPop = mainV_q & mTready;

assign sTready = fwdMode ? (~mainV_q | mTready) : ~skidV_q;
assign mTvalid = revMode ? (skidV_q | sTvalid) : mainV_q;
assign mTdata  = revMode ? (skidV_q ? skidD_q : sSum) : mainD_q;
assign mTlast  = revMode ? (skidV_q ? skidL_q : sTlast) : mainL_q;

always @(posedge clock or negedge rst_n) begin
   if (!rst_n) begin
      mainV_q <= 1'h0;
      mainD_q <= 32'h0000_0000;
      mainL_q <= 1'h0;
      skidV_q <= 1'h0;
      skidD_q <= 32'h0000_0000;
      skidL_q <= 1'h0;
   end else if (revMode) begin
      // only the ready path is registered; skid catches one word
      if (skidV_q && mTready) begin
         skidV_q <= 1'h0;
      end else if (sIn && !mTready) begin
         skidV_q <= 1'h1;
         skidD_q <= sSum;
         skidL_q <= sTlast;
      end
   end else begin
      if (mainPop) begin
         if (skidV_q) begin
            mainD_q <= skidD_q;
            mainL_q <= skidL_q;
            skidV_q <= 1'h0;
         end else if (sIn) begin
            mainD_q <= sSum;
            mainL_q <= sTlast;
         end else begin
            mainV_q <= 1'h0;
         end
      end else if (sIn) begin
         if (!mainV_q) begin
            mainV_q <= 1'h1;
            mainD_q <= sSum;
            mainL_q <= sTlast;
         end else begin
            skidV_q <= 1'h1;
            skidD_q <= sSum;
            skidL_q <= sTlast;
         end
      end
   end
end

endmodule // sppw_core

// >>> tb/sppw_core_sva.sv
/*
  port checker of the wrapper, bound to the core.
  assumes one clock and an async active-low reset.
*/
`timescale 1ns/1ns
module sppw_checker (
   input wire        clock,
   input wire        rst_n,
   input wire        psel,
   input wire        penable,
   input wire [7:0]  paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        continueIn,
   input wire        done,
   input wire        ready,
   input wire [31:0] argAData,
   input wire        argAValid,
   input wire        argAAck,
   input wire        argAEmptyN,
   input wire        argARead,
   input wire        argBValid,
   input wire        argBFullN,
   input wire        argBWrite,
   input wire [7:0]  ramAddr,
   input wire        ramCe,
   input wire        ramWe,
   input wire [31:0] ramWData,
   input wire [41:0] ramBus,
   input wire [31:0] mTdata,
   input wire        mTlast,
   input wire        mTvalid,
   input wire        mTready
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   apb_no_wait_a: assert property (psel && penable |-> pready)
      else $error("access without ready");
   bad_addr_err_a: assert property (psel && penable && paddr > 8'h18
      |-> pslverr) else $error("unmapped access not flagged");
   good_addr_ok_a: assert property (psel && penable && paddr <= 8'h18
      && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access flagged");
   hs_take_a: assert property (argAAck && argAValid |-> ready)
      else $error("handshake without take");
   ram_bundle_a: assert property (ramBus == {ramCe, ramWe, ramAddr,
      ramWData}) else $error("bundled ram view differs");
   read_then_write_a: assert property (ramCe && !ramWe
      |-> ##2 ramCe && ramWe) else $error("no write after read");
   take_reads_ram_a: assert property (ready |=> ramCe && !ramWe
      && ramAddr == $past(argAData[7:0]))
      else $error("ram read missing after take");
   bvalid_write_a: assert property ($rose(argBValid) |-> ramCe && ramWe)
      else $error("valid rose outside write");
   queue_read_a: assert property (argARead |-> argAEmptyN
      ##1 ramCe && !ramWe)
      else $error("queue read without memory read");
   queue_write_a: assert property (argBWrite |-> argBFullN
      ##1 !argBWrite)
      else $error("queue write not a single strobe");
   done_release_a: assert property (done && continueIn |=> !done)
      else $error("done held after continue");
   stream_hold_a: assert property (mTvalid && !mTready |=> mTvalid
      && $stable(mTdata) && $stable(mTlast))
      else $error("stream word dropped while stalled");
endmodule // sppw_checker

bind sppw_core sppw_checker sppw_checker_i (.clock(clock), .rst_n(rst_n),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .continueIn(continueIn), .done(done), .ready(ready),
   .argAData(argAData), .argAValid(argAValid), .argAAck(argAAck),
   .argAEmptyN(argAEmptyN), .argARead(argARead), .argBValid(argBValid),
   .argBFullN(argBFullN), .argBWrite(argBWrite), .ramAddr(ramAddr),
   .ramCe(ramCe), .ramWe(ramWe), .ramWData(ramWData), .ramBus(ramBus),
   .mTdata(mTdata), .mTlast(mTlast), .mTvalid(mTvalid), .mTready(mTready));

// >>> tb/sppw_far_model.sv
/*
  memory behind the discrete ram port.
  assumes reads answer one cycle after the enable.
*/
`timescale 1ns/1ns
module sppw_far_model (
   input  wire         clock,
   input  wire  [7:0]  ramAddr,
   input  wire         ramCe,
   input  wire         ramWe,
   input  wire  [31:0] ramWData,
   output logic [31:0] ramRData
);
   logic [31:0] mem [0:255];
   initial begin
      ramRData = 32'h5A5A_5A5A;
      for (int i = 0; i < 256; i++) mem[i] = 32'(i * 3);
   end
   // stale read data is inverted so a late sample cannot pass
   always @(posedge clock) begin
      if (ramCe && ramWe) mem[ramAddr] <= ramWData;
      if (ramCe && !ramWe) ramRData <= mem[ramAddr];
      else ramRData <= ~ramRData;
   end
endmodule // sppw_far_model

// >>> tb/test_sppw_core.sv
/*
  self-checking bench of the wrapper core.
  assumes the far model as memory; the bench plays caller and stream.
*/
`timescale 1ns/1ns
`include "sppw_defs.vh"
module test_sppw_core;
   logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, argAData = 0, sTdata = 0, rdat;
   logic        start = 0, continueIn = 0, argAValid = 0, argAEmptyN = 0;
   logic        argBAck = 0, argBFullN = 0, sTlast = 0, sTvalid = 0;
   logic        mTready = 0, rerr;
   logic [63:0] offsetIn = 64'h0000_0002_0000_0000;
   logic [31:0] shadow [0:255];
   wire  [31:0] prdata, argBData, ramWData, ramRData, mTdata;
   wire         pready, pslverr, idle, done, ready, argAAck, argARead;
   wire         argBValid, argBWrite, ramCe, ramWe, sTready, mTlast, mTvalid;
   wire  [7:0]  ramAddr;
   wire  [41:0] ramBus;
   wire  [63:0] mstAddr;
   int          errCount = 0, checkCount = 0;
   localparam logic [31:0] ADD = 32'h0000_0005;

   always #25 clock = ~clock;

   sppw_core sppw_core_i (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .start(start),
      .continueIn(continueIn), .idle(idle), .done(done), .ready(ready),
      .argAData(argAData), .argAValid(argAValid), .argAAck(argAAck),
      .argAEmptyN(argAEmptyN), .argARead(argARead), .argBData(argBData),
      .argBValid(argBValid), .argBAck(argBAck), .argBFullN(argBFullN),
      .argBWrite(argBWrite), .ramAddr(ramAddr), .ramCe(ramCe),
      .ramWe(ramWe), .ramWData(ramWData), .ramRData(ramRData),
      .ramBus(ramBus), .offsetIn(offsetIn), .mstAddr(mstAddr),
      .sTdata(sTdata), .sTlast(sTlast), .sTvalid(sTvalid),
      .sTready(sTready), .mTdata(mTdata), .mTlast(mTlast),
      .mTvalid(mTvalid), .mTready(mTready));
   sppw_far_model sppw_far_model_i (.clock(clock), .ramAddr(ramAddr),
      .ramCe(ramCe), .ramWe(ramWe), .ramWData(ramWData),
      .ramRData(ramRData));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("ERROR %0t mismatch got %h want %h", $time, seen, exp);
      end
   endtask
   task wrapUp;
      $display("checks %0d errors %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      // no wait-state count is assumed; only the watchdog ends a hang
      do @(posedge clock); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // one call; a and b wait on the far side before they are taken
   task callA(input logic [7:0] a, input logic chain, input logic queue);
      logic [31:0] exp;
      exp = 32'(a) + shadow[a] + ADD;
      shadow[a] = exp;
      argAData <= 32'(a);
      start <= 1;
      repeat (3) @(posedge clock);
      chk(ready, 1'b0);
      argAValid <= 1;
      argAEmptyN <= 1;
      do @(posedge clock); while (ready !== 1'b1);
      chk(argAAck, !queue);
      chk(argARead, queue);
      start <= 0;
      argAValid <= 0;
      argAEmptyN <= 0;
      // a registered a must not follow the pin after the take
      if (queue) argAData <= 32'hFFFF_FFFF;
      do @(posedge clock); while (ramWe !== 1'b1);
      repeat (2) @(posedge clock);
      chk(argBValid, !queue);
      chk(argBWrite, 1'b0);
      argBAck <= 1;
      argBFullN <= 1;
      do @(posedge clock); while (done !== 1'b1);
      argBAck <= 0;
      argBFullN <= 0;
      chk(argBData, exp);
      if (chain) begin
         repeat (3) @(posedge clock);
         chk(done, 1'b1);
         continueIn <= 1;
         @(posedge clock);
         continueIn <= 0;
      end
      @(posedge clock);
      chk(idle, 1'b1);
      apb(0, `SPPW_OFF_RESULT, 0);
      chk(rdat, exp);
      chk(argBData, queue ? exp : 32'h0000_0000);
   endtask
   // three words with the sink stalling before each
   task streamTest;
      fork
         begin
            for (int i = 0; i < 3; i++) begin
               sTdata <= 32'(i + 1) << 8;
               sTlast <= (i == 2);
               sTvalid <= 1;
               do @(posedge clock); while (sTready !== 1'b1);
            end
            // drop valid at once, or the last word is sent twice
            sTvalid <= 0;
         end
         for (int j = 0; j < 3; j++) begin
            mTready <= 0;
            repeat (3) @(posedge clock);
            mTready <= 1;
            do @(posedge clock); while (mTvalid !== 1'b1);
            chk(mTdata, (32'(j + 1) << 8) + ADD);
            chk(mTlast, j == 2);
         end
      join
      sTvalid <= 0;
      sTdata <= 32'hDEAD_BEEF;
   endtask

   initial begin
      logic [31:0] c;
      logic        acc;
      for (int i = 0; i < 256; i++) shadow[i] = 32'(i * 3);
      repeat (20) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      chk(idle, 1'b1);
      apb(0, `SPPW_OFF_CTRL, 0);
      chk(rdat, `SPPW_CTRL_RST);
      apb(1, `SPPW_OFF_RESULT, 32'hFFFF_FFFF);
      apb(0, `SPPW_OFF_RESULT, 0);
      chk(rdat, 0);
      apb(0, 8'h40, 0);
      chk({rerr, rdat}, 33'h1_0000_0000);
      apb(1, `SPPW_OFF_ADDEND, ADD);
      apb(1, `SPPW_OFF_CTRL, 32'h0000_0C91);
      callA(8'h10, 0, 0);
      callA(8'h10, 0, 0);
      chk(mstAddr, 64'h0000_0000_0000_0040);
      apb(0, `SPPW_OFF_CALLS, 0);
      chk(rdat, 2);
      apb(1, `SPPW_OFF_CTRL, 32'h0000_0FD9);
      callA(8'h30, 0, 1);
      apb(1, `SPPW_OFF_OFSLO, 32'h0000_0100);
      apb(1, `SPPW_OFF_OFSHI, 32'h0000_0001);
      for (int k = 0; k < 2; k++) begin
         apb(1, `SPPW_OFF_CTRL, k ? 32'h0000_5C92 : 32'h0000_3C92);
         callA(8'h20, 1, 0);
         chk(mstAddr, (k ? 64'h0000_0001_0000_0100 : offsetIn) + 64'h80);
      end
      // forward, reverse and both placements, each from an empty stream
      for (int s = 1; s < 4; s++) begin
         apb(1, `SPPW_OFF_CTRL, 32'h0000_5092 | (s << 10));
         streamTest;
      end
      apb(0, `SPPW_OFF_CALLS, 0);
      c = rdat;
      apb(1, `SPPW_OFF_CTRL, 32'h0000_0C00);
      acc = 0;
      repeat (20) begin
         @(posedge clock);
         acc = acc | idle | done | ready;
      end
      chk(acc, 1'b0);
      apb(0, `SPPW_OFF_CALLS, 0);
      chk(rdat > c, 1'b1);
      wrapUp;
   end

   initial begin
      #2_000_000;
      errCount++;
      wrapUp;
   end
endmodule // test_sppw_core
